// >>> core/srsb_pkg.sv
// Package for the service request status byte block: bit positions,
// reset value and voltage threshold.
// Assumes one clock domain and event inputs that are one-cycle pulses.
//
// Functional notes
// - Request bit 7 is set whenever bit 2, 3, 4, 6 or 8 is set.
// - Data ready also raises request bit, only after data ready notify on.
// - Emergency bit 8 set on dangerous condition, qualified by bits 2, 4, 6.
// - With bit 8 set, bits 2, 4, 6 carry emergency meanings instead.
// - Lid opens during or at measurement start above 42 V: set bits 2, 8.
// - User mode: lid open or shorting connector absent sets bits 2, 8.
// - Unit output shut down for protection sets bits 4 and 8.
// - Momentary power loss resetting unit output sets bits 6 and 8.
// - Serial poll clears every status bit except busy.
// - Device clear clears every bit except data ready and busy.
// - Data ready set on complete data; cleared on transfer start or buffer clear.
// - Busy follows measurement or calibration and never raises request bit.
// - Syntax error bit set on erroneous remote program code.
// - Self-test fail set on failing test, cleared on a later pass unless bit 8 is set.
package srsb_pkg;
  // Bit indices, zero based: documented bit n sits at index n-1.
  localparam int SRSB_B_DRDY   = 0;
  localparam int SRSB_B_SYNTAX = 1;
  localparam int SRSB_B_END    = 2;
  localparam int SRSB_B_ILLEG  = 3;
  localparam int SRSB_B_BUSY   = 4;
  localparam int SRSB_B_STFAIL = 5;
  localparam int SRSB_B_RQS    = 6;
  localparam int SRSB_B_EMERG  = 7;
  localparam logic [7:0] SRSB_RESET = 8'h00;
  // Output voltage threshold for lid interlock, in volts.
  localparam int SRSB_LID_VOLTS = 42;

  // Event pulses arriving from the instrument's controller.
  typedef struct packed {
    logic data_complete;
    logic transfer_start;
    logic buffer_clear_cmd;
    logic syntax_err;
    logic op_done;
    logic illegal_prog;
    logic selftest_fail;
    logic selftest_pass;
    logic lid_opened;
    logic meas_start;
    logic smu_shutdown;
    logic power_loss;
  } srsb_evt_t;
endpackage

// >>> core/srsb_status.sv
// Service request status byte: sticky flags, request summary, clears.
// Assumes events are synchronous one-cycle pulses on mclk; levels for
// busy, lid, connector, user mode and output voltage are steady inputs.
`timescale 1ns/1ps
`default_nettype none
module srsb_status
  import srsb_pkg::*;
#(
  parameter int VOLT_W = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Event pulses
  input  wire srsb_evt_t        evt,
  // Levels
  input  wire logic             busy_op,
  input  wire logic             lid_open,
  input  wire logic             short_conn_present,
  input  wire logic             user_mode,
  input  wire logic [VOLT_W-1:0] out_volts_mag,
  input  wire logic             measuring,
  // Commands from the bus
  input  wire logic             data_ready_notify_on_cmd,
  input  wire logic             data_ready_notify_off_cmd,
  input  wire logic             serial_poll,
  input  wire logic             device_clear,
  // Status out
  output logic [7:0]            status_byte,
  output logic                  rqs
);

  initial begin
    if (VOLT_W < 7) $error("VOLT_W too narrow for threshold");
  end

  logic [7:0] flags;
  logic       notify_on;
  logic [7:0] set_v;
  logic [7:0] keep_v;
  logic [7:0] next_flags;

  // Lid interlock: high-voltage measurement or any user mode violation.
  wire hv_meas  = out_volts_mag > VOLT_W'(SRSB_LID_VOLTS);
  wire lid_hv   = hv_meas && ((evt.lid_opened && measuring) ||
                  (evt.meas_start && lid_open));
  wire lid_user = user_mode && (lid_open || !short_conn_present);
  wire emerg_lid = lid_hv || lid_user;
  // Emergency sources each set their qualifier with bit 8.
  wire emerg = emerg_lid || evt.smu_shutdown || evt.power_loss;

  always_comb begin
    set_v = 8'h00;
    set_v[SRSB_B_DRDY]   = evt.data_complete;
    set_v[SRSB_B_SYNTAX] = evt.syntax_err || emerg_lid;
    set_v[SRSB_B_END]    = evt.op_done;
    set_v[SRSB_B_ILLEG]  = evt.illegal_prog || evt.smu_shutdown;
    set_v[SRSB_B_STFAIL] = evt.selftest_fail || evt.power_loss;
    set_v[SRSB_B_EMERG]  = emerg;
  end

  // Clear mask: ones mark bits that survive this cycle.
  always_comb begin
    keep_v = 8'hff;
    if (evt.transfer_start || evt.buffer_clear_cmd) begin
      keep_v[SRSB_B_DRDY] = 1'b0;
    end
    // With bit 8 set, bit 6 reports a power failure, so a pass keeps it.
    if (evt.selftest_pass && !flags[SRSB_B_EMERG]) begin
      keep_v[SRSB_B_STFAIL] = 1'b0;
    end
    if (device_clear) begin
      keep_v = keep_v & 8'h11;
    end
    if (serial_poll) begin
      keep_v = keep_v & 8'h10;
    end
  end

  // Set wins over clear; busy and request bits are computed below.
  always_comb begin
    next_flags = (flags & keep_v) | set_v;
    next_flags[SRSB_B_BUSY] = 1'b0;
    next_flags[SRSB_B_RQS]  = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags <= SRSB_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      notify_on <= 1'b0;
    end else if (data_ready_notify_on_cmd) begin
      notify_on <= 1'b1;
    end else if (data_ready_notify_off_cmd) begin
      notify_on <= 1'b0;
    end
  end

  // Request summary; busy is excluded.
  wire rqs_v = flags[SRSB_B_SYNTAX] | flags[SRSB_B_END] |
               flags[SRSB_B_ILLEG]  | flags[SRSB_B_STFAIL] |
               flags[SRSB_B_EMERG]  |
               (flags[SRSB_B_DRDY] & notify_on);

  always_comb begin
    status_byte = flags;
    status_byte[SRSB_B_BUSY] = busy_op;
    status_byte[SRSB_B_RQS]  = rqs_v;
  end
  assign rqs = rqs_v;

  // Assertions. The request sources are bits 2, 3, 4, 6 and 8 (mask ae).

  // Any request source raises the request bit.
  AST_RQS_SUM: assert property (
    @(posedge mclk) disable iff (rst)
    (|(flags & 8'hae)) |-> rqs)
    else $error("request bit not set");

  // The request bit never stands without a cause.
  AST_RQS_CAUSE: assert property (
    @(posedge mclk) disable iff (rst)
    rqs |-> ((|(flags & 8'hae)) || (flags[0] && notify_on)))
    else $error("request bit set without a source");

  // The byte carries the request bit at bit 7.
  AST_RQS_BIT: assert property (
    @(posedge mclk) disable iff (rst)
    status_byte[6] == rqs)
    else $error("request bit in byte differs from request");

  // Data ready raises the request only once notify is on.
  AST_DRDY_NOTIFY: assert property (
    @(posedge mclk) disable iff (rst)
    (flags[0] && notify_on) |-> rqs)
    else $error("data ready with notify did not request");

  // Without notify, data ready alone stays quiet.
  AST_DRDY_QUIET: assert property (
    @(posedge mclk) disable iff (rst)
    (flags[0] && !notify_on && !(|(flags & 8'hae))) |-> !rqs)
    else $error("data ready raised request without notify");

  // The notify on command takes effect on the next edge.
  AST_NOTIFY_ON: assert property (
    @(posedge mclk) disable iff (rst)
    data_ready_notify_on_cmd |=> notify_on)
    else $error("notify on command not taken");

  // A protective shutdown or a power loss sets bit 8.
  AST_EMERG_SET: assert property (
    @(posedge mclk) disable iff (rst)
    (evt.smu_shutdown || evt.power_loss) |=> flags[7])
    else $error("emergency bit not set");

  // Bit 8 never stands without one of its qualifiers.
  AST_EMERG_QUAL: assert property (
    @(posedge mclk) disable iff (rst)
    flags[7] |-> (flags[1] || flags[3] || flags[5]))
    else $error("emergency bit without qualifier");

  // The controller sees the qualifiers and bit 8 exactly as held.
  AST_BYTE_FLAGS: assert property (
    @(posedge mclk) disable iff (rst)
    (status_byte & 8'haf) == (flags & 8'haf))
    else $error("status byte differs from held flags");

  // High-voltage lid events set bits 2 and 8.
  AST_LID_HV: assert property (
    @(posedge mclk) disable iff (rst)
    (((evt.lid_opened && measuring) || (evt.meas_start && lid_open)) &&
     (out_volts_mag > VOLT_W'(SRSB_LID_VOLTS))) |=> (flags[1] && flags[7]))
    else $error("high voltage lid event not flagged");

  // At or below the threshold, outside user mode, the lid raises no alarm.
  AST_LID_LOW: assert property (
    @(posedge mclk) disable iff (rst)
    (!user_mode && !(out_volts_mag > VOLT_W'(SRSB_LID_VOLTS)) &&
     !evt.smu_shutdown && !evt.power_loss && !flags[7]) |=> !flags[7])
    else $error("emergency set below threshold");

  // User mode flags an open lid or a missing shorting connector.
  AST_USER_LID: assert property (
    @(posedge mclk) disable iff (rst)
    (user_mode && (lid_open || !short_conn_present)) |=>
    (flags[1] && flags[7]))
    else $error("user mode interlock not flagged");

  // A protective shutdown sets bits 4 and 8.
  AST_SMU: assert property (
    @(posedge mclk) disable iff (rst)
    evt.smu_shutdown |=> (flags[3] && flags[7]))
    else $error("shutdown did not set bits 4 and 8");

  // A power loss sets bits 6 and 8.
  AST_PWR: assert property (
    @(posedge mclk) disable iff (rst)
    evt.power_loss |=> (flags[5] && flags[7]))
    else $error("power loss did not set bits 6 and 8");

  // A serial poll with no new event leaves nothing held.
  AST_POLL: assert property (
    @(posedge mclk) disable iff (rst)
    (serial_poll && set_v == 8'h00) |=> (flags == 8'h00))
    else $error("serial poll did not clear");

  // Without a clear, no held bit drops.
  AST_STICKY: assert property (
    @(posedge mclk) disable iff (rst)
    (!serial_poll && !device_clear && !evt.transfer_start &&
     !evt.buffer_clear_cmd && !evt.selftest_pass) |=>
    ((flags & $past(flags)) == $past(flags)))
    else $error("held bit dropped without a clear");

  // A device clear keeps only data ready.
  AST_DCLR: assert property (
    @(posedge mclk) disable iff (rst)
    (device_clear && !serial_poll && set_v == 8'h00 && !evt.transfer_start
     && !evt.buffer_clear_cmd) |=> (flags[0] == $past(flags[0])
     && (flags & 8'hfe) == 8'h00))
    else $error("device clear wrong");

  // Complete data sets data ready.
  AST_DRDY_SET: assert property (
    @(posedge mclk) disable iff (rst)
    evt.data_complete |=> flags[0])
    else $error("data ready not set");

  // Transfer start or buffer clear drops data ready.
  AST_DRDY_CLR: assert property (
    @(posedge mclk) disable iff (rst)
    ((evt.transfer_start || evt.buffer_clear_cmd) && !evt.data_complete)
    |=> !flags[0])
    else $error("data ready not cleared");

  // The busy bit follows the running operation.
  AST_BUSY_BIT: assert property (
    @(posedge mclk) disable iff (rst)
    status_byte[4] == busy_op)
    else $error("busy bit wrong");

  // Busy alone never raises the request.
  AST_BUSY_NO_RQS: assert property (
    @(posedge mclk) disable iff (rst)
    (busy_op && !(|(flags & 8'hae)) && !(flags[0] && notify_on)) |-> !rqs)
    else $error("busy raised request");

  // An erroneous program code sets the syntax error bit.
  AST_SYNTAX: assert property (
    @(posedge mclk) disable iff (rst)
    evt.syntax_err |=> flags[1])
    else $error("syntax error bit not set");

  // A failing self-test sets bit 6.
  AST_STFAIL_SET: assert property (
    @(posedge mclk) disable iff (rst)
    evt.selftest_fail |=> flags[5])
    else $error("self-test fail bit not set");

  // A later pass drops bit 6 when no emergency holds it.
  AST_STFAIL_CLR: assert property (
    @(posedge mclk) disable iff (rst)
    (evt.selftest_pass && !evt.selftest_fail && !evt.power_loss &&
     !flags[7]) |=> !flags[5])
    else $error("self-test pass did not clear");

  // A finished test, plot or print sets end status.
  AST_END: assert property (
    @(posedge mclk) disable iff (rst)
    evt.op_done |=> flags[2])
    else $error("end status bit not set");

  // An invalid program sets the illegal program bit.
  AST_ILLEG: assert property (
    @(posedge mclk) disable iff (rst)
    evt.illegal_prog |=> flags[3])
    else $error("illegal program bit not set");

  // Main scenarios.
  COV_DCLR: cover property (@(posedge mclk) disable iff (rst)
    flags[0] && device_clear ##1 flags[0]);
  COV_LID: cover property (@(posedge mclk) disable iff (rst)
    lid_hv ##1 rqs);
  COV_POLL: cover property (@(posedge mclk) disable iff (rst)
    rqs ##1 serial_poll ##1 !rqs);
  COV_EMERG: cover property (@(posedge mclk) disable iff (rst)
    evt.smu_shutdown ##1 rqs);
  COV_DRDY: cover property (@(posedge mclk) disable iff (rst)
    notify_on && evt.data_complete ##1 rqs);

endmodule
`default_nettype wire

// >>> tb/srsb_host.sv
// Bus controller model: serial poll and device clear of the status byte.
// Assumes the block samples its command pulses on mclk rising edges.
`timescale 1ns/1ps
`default_nettype none
module srsb_host (
  // Clock and status
  input  wire logic       mclk,
  input  wire logic [7:0] status_byte,
  // Bus commands
  output var  logic       serial_poll,
  output var  logic       device_clear
);
  initial serial_poll = 1'b0;
  initial device_clear = 1'b0;
  // The byte is read while the poll is held, before its clear lands.
  task automatic poll(output logic [7:0] v);
    @(posedge mclk) serial_poll <= 1'b1;
    #1 v = status_byte;
    @(posedge mclk) serial_poll <= 1'b0;
    #1;
  endtask
  task automatic dclr();
    @(posedge mclk) device_clear <= 1'b1;
    @(posedge mclk) device_clear <= 1'b0;
    #1;
  endtask
  // Data output is asked for only once a poll shows data ready.
  task automatic wait_ready(output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < 20 && v[0] !== 1'b1; i++) poll(v);
  endtask
endmodule
`default_nettype wire

// >>> tb/service_request_status_byte_test.sv
// Bench for the status byte block: pulses events, checks byte and request.
// Assumes the controller model srsb_host for polls and device clears.
`timescale 1ns/1ps
`default_nettype none
module service_request_status_byte_test;
  import srsb_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, busy_op = 1'b0, lid_open = 1'b0;
  logic        user_mode = 1'b0, measuring = 1'b0, short_conn_present = 1'b1;
  logic        dr_on = 1'b0, dr_off = 1'b0, serial_poll, device_clear, rqs;
  logic [15:0] out_volts_mag = 16'h0000;
  logic [11:0] evt = 12'h000;
  logic [7:0]  status_byte, v;
  int          n_errors = 0, num_checks = 0, cyc = 0;
  always #50 mclk = ~mclk;
  srsb_status i_dut (.mclk(mclk), .rst(rst), .evt(srsb_evt_t'(evt)),
    .busy_op(busy_op), .lid_open(lid_open), .user_mode(user_mode),
    .short_conn_present(short_conn_present), .out_volts_mag(out_volts_mag),
    .measuring(measuring), .data_ready_notify_on_cmd(dr_on),
    .data_ready_notify_off_cmd(dr_off), .serial_poll(serial_poll),
    .device_clear(device_clear), .status_byte(status_byte), .rqs(rqs));
  srsb_host i_host (.mclk(mclk), .status_byte(status_byte),
    .serial_poll(serial_poll), .device_clear(device_clear));
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Event bits from the top: data_complete down to power_loss.
  task automatic ev(logic [11:0] e, logic [7:0] x);
    @(posedge mclk) evt <= e;
    @(posedge mclk) evt <= 12'h000;
    #1 chk("status_byte", status_byte, x);
    chk("rqs", {7'h00, rqs}, {7'h00, x[6]});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_flags();
    logic [11:0] e[6] = '{12'h100, 12'h080, 12'h040, 12'h020, 12'h002, 12'h001};
    logic [7:0]  x[6] = '{8'h42, 8'h44, 8'h48, 8'h60, 8'hc8, 8'he0};
    for (int i = 0; i < 6; i++) begin
      ev(e[i], x[i]);
      i_host.poll(v);
      chk("polled", v, x[i]);
      chk("after_poll", status_byte, 8'h00);
    end
  endtask
  task automatic t_ready();
    ev(12'h800, 8'h01);
    @(posedge mclk) dr_on <= 1'b1;
    @(posedge mclk) dr_on <= 1'b0;
    ev(12'h400, 8'h00);
    ev(12'h800, 8'h41);
    ev(12'h200, 8'h00);
    ev(12'h800, 8'h41);
    i_host.wait_ready(v);
    chk("ready_poll", v, 8'h41);
    @(posedge mclk) busy_op <= 1'b1;
    ev(12'h000, 8'h10);
    i_host.poll(v);
    chk("busy_kept", status_byte, 8'h10);
    @(posedge mclk);
    busy_op <= 1'b0;
    dr_off <= 1'b1;
    @(posedge mclk) dr_off <= 1'b0;
  endtask
  task automatic t_dclr();
    @(posedge mclk) busy_op <= 1'b1;
    ev(12'h822, 8'hf9);
    i_host.dclr();
    chk("dev_clear", status_byte, 8'h11);
    @(posedge mclk) busy_op <= 1'b0;
    ev(12'h020, 8'h61);
    ev(12'h010, 8'h01);
    ev(12'h400, 8'h00);
  endtask
  task automatic t_lid();
    @(posedge mclk);
    measuring <= 1'b1;
    out_volts_mag <= 16'h002a;
    ev(12'h008, 8'h00);
    @(posedge mclk) out_volts_mag <= 16'h002b;
    ev(12'h008, 8'hc2);
    i_host.poll(v);
    @(posedge mclk);
    measuring <= 1'b0;
    lid_open <= 1'b1;
    ev(12'h004, 8'hc2);
    i_host.poll(v);
    @(posedge mclk);
    lid_open <= 1'b0;
    user_mode <= 1'b1;
    short_conn_present <= 1'b0;
    ev(12'h000, 8'hc2);
    @(posedge mclk);
    short_conn_present <= 1'b1;
    user_mode <= 1'b0;
    i_host.poll(v);
    chk("lid_cleared", status_byte, 8'h00);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    #1 chk("reset", status_byte, 8'h00);
    t_flags();
    t_ready();
    t_dclr();
    t_lid();
    end_sim();
  end
endmodule
`default_nettype wire
